// ==== design/msc_pkg.sv ====
// Register map, field layout, reset values and timing constants of the motion
// sensor configuration register group.
// Assumes a byte-wide register port inside the device, 250 MHz clock.
package msc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_ORIENT_MASK  = 8'h1c;
  localparam logic [7:0] ADDR_FEATURE_CTRL = 8'h1d;
  localparam logic [7:0] ADDR_IRQ_PIN_CTRL = 8'h1e;
  localparam logic [7:0] ADDR_MOTION_MASK  = 8'h1f;
  localparam logic [7:0] ADDR_TAP_MASK     = 8'h20;
  localparam logic [7:0] ADDR_OUT_FILTER   = 8'h21;
  localparam logic [7:0] ADDR_SELFTEST     = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_RELEASE  = 8'h1a;
  // Reset values
  localparam logic [7:0] RST_ORIENT_MASK   = 8'h3f;
  localparam logic [7:0] RST_FEATURE_CTRL  = 8'h4d;
  localparam logic [7:0] RST_IRQ_PIN_CTRL  = 8'h10;
  localparam logic [7:0] RST_MOTION_MASK   = 8'he0;
  localparam logic [7:0] RST_TAP_MASK      = 8'h3f;
  localparam logic [7:0] RST_OUT_FILTER    = 8'h02;
  localparam logic [7:0] SELFTEST_RESPONSE_IDLE      = 8'h55;
  localparam logic [7:0] SELFTEST_RESPONSE_ARMED     = 8'haa;
  // Writable-bit masks
  localparam logic [7:0] WMASK_ORIENT      = 8'h3f;
  localparam logic [7:0] WMASK_IRQ_PIN     = 8'h3c;
  localparam logic [7:0] WMASK_MOTION      = 8'he0;
  localparam logic [7:0] WMASK_TAP         = 8'h3f;
  localparam logic [7:0] WMASK_OUT_FILTER  = 8'hc7;
  // Field positions
  localparam int FC_REBOOT    = 7;
  localparam int FC_TILT_LO   = 5;
  localparam int FC_SELFTEST  = 4;
  localparam int FC_TAP_LO    = 2;
  localparam int FC_MOTION_LO = 0;
  localparam int IP_ENABLE    = 5;
  localparam int IP_POLARITY  = 4;
  localparam int IP_PULSE     = 3;
  localparam int IP_UNLATCH   = 2;
  localparam int MM_X         = 7;
  localparam int MM_Y         = 6;
  localparam int MM_Z         = 5;
  localparam int OF_HPF_LO    = 6;
  localparam int OF_LPF_LO    = 0;
  // Timing
  localparam int  CLK_HZ         = 250_000_000;
  localparam real PULSE_MS       = 0.05;
  localparam int  PULSE_CYCLES   = int'(PULSE_MS * 250_000.0);
  localparam int  REBOOT_CYCLES  = 64;
  localparam int  ACC_W          = 16;
  // Rate selection outputs as Hz numbers (tenths for tilt)
  localparam logic [9:0] LPF_HZ_25  = 10'd25;
endpackage : msc_pkg

// ==== design/msc_hpf_if.sv ====
// Interface carrying filter configuration and samples between the register
// group and its high-pass filter.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface msc_hpf_if;
  logic                           sample_en;
  logic [1:0]                     rolloff;
  logic signed [msc_pkg::ACC_W-1:0] din;
  logic signed [msc_pkg::ACC_W-1:0] dout;
  modport filt (input sample_en, input rolloff, input din, output dout);
  modport ctrl (output sample_en, output rolloff, output din, input dout);
endinterface : msc_hpf_if

// ==== design/msc_hpf.sv ====
// First-order recursive high-pass filter, one axis.
// Assumes sample_en pulses once per motion-rate sample.
`timescale 1ns/1ps
module msc_hpf
(
  input  wire logic    clock,
  input  wire logic    reset,
  msc_hpf_if.filt      hp
);
  localparam int W = msc_pkg::ACC_W;

  typedef struct packed {
    logic signed [W-1:0] prev_in;
    logic signed [W-1:0] out;
  } msc_hpf_st_t;

  msc_hpf_st_t st_r;
  msc_hpf_st_t st_nxt;
  logic signed [W+1:0] acc;
  logic signed [W+1:0] shifted;

  // recursive beta update
  // y = beta*(y + x - xprev), beta = 1 - 2^-(3+rolloff)
  always_comb
  begin
    st_nxt  = st_r;
    acc     = {{2{st_r.out[W-1]}}, st_r.out} + {{2{hp.din[W-1]}}, hp.din}
              - {{2{st_r.prev_in[W-1]}}, st_r.prev_in};
    shifted = acc >>> (3 + int'(hp.rolloff));
    if (hp.sample_en)
    begin
      st_nxt.out     = W'(acc - shifted);
      st_nxt.prev_in = hp.din;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign hp.dout = st_r.out;
endmodule : msc_hpf

// ==== design/msc_config_regs.sv ====
// Configuration register group of a three-axis motion sensor: masks, rates,
// interrupt pin control, self-test and reboot, high-pass filter.
// Assumes the serial front end delivers byte reads and writes as strobes.
//
// How it works
// - Orientation mask gates state-entry interrupts
// - Reboot bit holds one until done or REBOOT_LEN cycles
// - Tilt rate field selects four rates
// - Self-test loads aa, read reloads 55
// - Tap rate field selects four rates
// - Motion rate drives detection and filter
// - Pin enable gates interrupt pin
// - Polarity bit picks pin active level
// - Latched until release, or 0.05ms pulse
// - Unlatched pin follows motion when alone
// - X, Y, Z motion masks reset high
// - Six direction masks gate tap interrupts
// - Roll-off field selects filter beta
// - Low-pass rate codes, 000/111 invalid
// - Operating-mode bit zero means stand-by
// - Release read clears latched interrupt
`timescale 1ns/1ps
module msc_config_regs
#(
  parameter int PULSE_LEN  = msc_pkg::PULSE_CYCLES,
  parameter int REBOOT_LEN = msc_pkg::REBOOT_CYCLES
)
(
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_rd,
  output      logic [7:0]                  reg_rdata,
  input  wire logic                        operating_mode_bit,
  input  wire logic                        motion_enable,
  input  wire logic                        tap_enable,
  input  wire logic                        tilt_enable,
  input  wire logic [5:0]                  orient_enter,
  input  wire logic [5:0]                  tap_event,
  input  wire logic [2:0]                  motion_axis,
  input  wire logic                        motion_sample_en,
  input  wire logic signed [msc_pkg::ACC_W-1:0] motion_din,
  input  wire logic                        reboot_done,
  output      logic                        reboot_busy,
  output      logic [1:0]                  tilt_rate_sel,
  output      logic [1:0]                  tap_rate_sel,
  output      logic [1:0]                  motion_rate_sel,
  output      logic [2:0]                  lpf_rate_sel,
  output      logic                        lpf_rate_valid,
  output      logic signed [msc_pkg::ACC_W-1:0] hpf_out,
  output      logic                        irq_pending,
  output      logic                        irq_pin
);
  localparam int PW = $clog2(PULSE_LEN + 1);
  localparam int RW = $clog2(REBOOT_LEN + 1);

  typedef struct packed {
    logic [7:0]    orient_mask;
    logic [7:0]    feature;
    logic [7:0]    pin_ctrl;
    logic [7:0]    motion_mask;
    logic [7:0]    tap_mask;
    logic [7:0]    out_filter;
    logic [7:0]    selftest_response;
    logic [7:0]    rdata;
    logic          latched;
    logic          pulse_on;
    logic [PW-1:0] pulse_cnt;
    logic [RW-1:0] reboot_cnt;
    logic          pin;
  } msc_st_t;

  msc_st_t    st_r;
  msc_st_t    st_nxt;
  logic       evt;
  logic       motion_now;
  logic       unlatched_mode;
  logic       assert_lvl;
  logic [7:0] wv;

  msc_hpf_if  hp ();

  msc_hpf u_hpf
  (
    .clock (clock),
    .reset (reset),
    .hp    (hp)
  );

  assign hp.sample_en = motion_sample_en;
  assign hp.rolloff   = st_r.out_filter[msc_pkg::OF_HPF_LO +: 2];
  assign hp.din       = motion_din;
  assign hpf_out      = hp.dout;

  // Event gathering and pin mode
  always_comb
  begin
    motion_now = motion_enable &
                 |(motion_axis & {st_r.motion_mask[msc_pkg::MM_X],
                                  st_r.motion_mask[msc_pkg::MM_Y],
                                  st_r.motion_mask[msc_pkg::MM_Z]});
    evt = motion_now
        | (tilt_enable & |(orient_enter & st_r.orient_mask[5:0]))
        | (tap_enable & |(tap_event & st_r.tap_mask[5:0]));
    unlatched_mode = st_r.pin_ctrl[msc_pkg::IP_UNLATCH] & motion_enable
                     & ~tap_enable & ~tilt_enable;
  end

  // Register file, interrupt latch, pulse and reboot sequencing
  always_comb
  begin
    st_nxt = st_r;
    wv     = reg_wdata;
    if (reg_rd && reg_addr == msc_pkg::ADDR_IRQ_RELEASE)
      st_nxt.latched = 1'b0;
    // Set beats clear in the same cycle
    if (evt)
      st_nxt.latched = 1'b1;
    if (st_r.pulse_on)
    begin
      if (st_r.pulse_cnt == PW'(PULSE_LEN - 1))
        st_nxt.pulse_on = 1'b0;
      st_nxt.pulse_cnt = st_r.pulse_cnt + PW'(1);
    end
    if (evt && !st_r.latched)
    begin
      st_nxt.pulse_on  = 1'b1;
      st_nxt.pulse_cnt = '0;
    end
    if (st_r.feature[msc_pkg::FC_REBOOT])
    begin
      st_nxt.reboot_cnt = st_r.reboot_cnt + RW'(1);
      if (reboot_done || st_r.reboot_cnt == RW'(REBOOT_LEN - 1))
      begin
        st_nxt.feature[msc_pkg::FC_REBOOT] = 1'b0;
        st_nxt.reboot_cnt                  = '0;
      end
    end
    // Read mux; reserved bits stored as zero
    st_nxt.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        msc_pkg::ADDR_ORIENT_MASK:  st_nxt.rdata = st_r.orient_mask;
        msc_pkg::ADDR_FEATURE_CTRL: st_nxt.rdata = st_r.feature;
        msc_pkg::ADDR_IRQ_PIN_CTRL: st_nxt.rdata = st_r.pin_ctrl;
        msc_pkg::ADDR_MOTION_MASK:  st_nxt.rdata = st_r.motion_mask;
        msc_pkg::ADDR_TAP_MASK:     st_nxt.rdata = st_r.tap_mask;
        msc_pkg::ADDR_OUT_FILTER:   st_nxt.rdata = st_r.out_filter;
        msc_pkg::ADDR_SELFTEST:
        begin
          st_nxt.rdata = st_r.selftest_response;
          if (st_r.feature[msc_pkg::FC_SELFTEST])
          begin
            st_nxt.feature[msc_pkg::FC_SELFTEST] = 1'b0;
            st_nxt.selftest_response                       = msc_pkg::SELFTEST_RESPONSE_IDLE;
          end
        end
        default:                    st_nxt.rdata = 8'h00;
      endcase
    end
    if (reg_wr && !operating_mode_bit)
    begin
      unique case (reg_addr)
        msc_pkg::ADDR_ORIENT_MASK:  st_nxt.orient_mask = wv & msc_pkg::WMASK_ORIENT;
        msc_pkg::ADDR_FEATURE_CTRL:
        begin
          st_nxt.feature[6:0] = wv[6:0];
          // Self-test bit sticks until the response is read
          st_nxt.feature[msc_pkg::FC_SELFTEST] = st_r.feature[msc_pkg::FC_SELFTEST]
                                                | wv[msc_pkg::FC_SELFTEST];
          if (wv[msc_pkg::FC_SELFTEST])
            st_nxt.selftest_response = msc_pkg::SELFTEST_RESPONSE_ARMED;
          if (wv[msc_pkg::FC_REBOOT])
            st_nxt.feature[msc_pkg::FC_REBOOT] = 1'b1;
        end
        msc_pkg::ADDR_IRQ_PIN_CTRL: st_nxt.pin_ctrl    = wv & msc_pkg::WMASK_IRQ_PIN;
        msc_pkg::ADDR_MOTION_MASK:  st_nxt.motion_mask = wv & msc_pkg::WMASK_MOTION;
        msc_pkg::ADDR_TAP_MASK:     st_nxt.tap_mask    = wv & msc_pkg::WMASK_TAP;
        msc_pkg::ADDR_OUT_FILTER:   st_nxt.out_filter  = wv & msc_pkg::WMASK_OUT_FILTER;
        default:                    st_nxt.pin         = st_r.pin;
      endcase
    end
    // Pin level, registered to avoid glitches on the pad
    if (unlatched_mode)
      assert_lvl = motion_now;
    else if (st_r.pin_ctrl[msc_pkg::IP_PULSE])
      assert_lvl = st_nxt.pulse_on;
    else
      assert_lvl = st_nxt.latched;
    st_nxt.pin = (assert_lvl & st_r.pin_ctrl[msc_pkg::IP_ENABLE])
               ~^ st_r.pin_ctrl[msc_pkg::IP_POLARITY];
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st_r             <= '0;
      st_r.orient_mask <= msc_pkg::RST_ORIENT_MASK;
      st_r.feature     <= msc_pkg::RST_FEATURE_CTRL;
      st_r.pin_ctrl    <= msc_pkg::RST_IRQ_PIN_CTRL;
      st_r.motion_mask <= msc_pkg::RST_MOTION_MASK;
      st_r.tap_mask    <= msc_pkg::RST_TAP_MASK;
      st_r.out_filter  <= msc_pkg::RST_OUT_FILTER;
      st_r.selftest_response     <= msc_pkg::SELFTEST_RESPONSE_IDLE;
      // Idle level for the reset polarity, so no false edge after reset
      st_r.pin         <= ~msc_pkg::RST_IRQ_PIN_CTRL[msc_pkg::IP_POLARITY];
    end
    else
      st_r <= st_nxt;
  end

  // Configuration outputs
  always_comb
  begin
    tilt_rate_sel   = st_r.feature[msc_pkg::FC_TILT_LO +: 2];
    tap_rate_sel    = st_r.feature[msc_pkg::FC_TAP_LO +: 2];
    motion_rate_sel = st_r.feature[msc_pkg::FC_MOTION_LO +: 2];
    // codes 000 and 111 flagged invalid
    lpf_rate_sel    = st_r.out_filter[msc_pkg::OF_LPF_LO +: 3];
    lpf_rate_valid  = (lpf_rate_sel != 3'h0) && (lpf_rate_sel != 3'h7);
  end

  assign reboot_busy = st_r.feature[msc_pkg::FC_REBOOT];
  assign irq_pending = st_r.latched;
  assign irq_pin     = st_r.pin;
  assign reg_rdata   = st_r.rdata;
endmodule : msc_config_regs

// ==== testbench/msc_config_regs_properties.sv ====
// Port checker for the config register group.
// Assumes it is bound onto msc_config_regs.
`timescale 1ns/1ps
module msc_checker
#(
  parameter int REBOOT_LEN = 64
)
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       operating_mode_bit,
  input wire logic [5:0] orient_enter,
  input wire logic [5:0] tap_event,
  input wire logic [2:0] motion_axis,
  input wire logic       reboot_busy,
  input wire logic [1:0] tilt_rate_sel,
  input wire logic [1:0] tap_rate_sel,
  input wire logic [1:0] motion_rate_sel,
  input wire logic [2:0] lpf_rate_sel,
  input wire logic       lpf_rate_valid,
  input wire logic       irq_pending
);
  // Slack of two cycles for the registered busy flag
  localparam int RB_MAX = REBOOT_LEN + 2;
  logic wr_ok;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Writes count only in stand-by
  assign wr_ok = reg_wr && !operating_mode_bit;

  a_mode_hold: assert property (!$past(reset) && $past(operating_mode_bit)
    |-> $stable({tilt_rate_sel, tap_rate_sel, motion_rate_sel, lpf_rate_sel}))
    else $error("rates moved while operating");
  a_rate_write: assert property (wr_ok && reg_addr == 8'h1d
    |=> {tilt_rate_sel, tap_rate_sel, motion_rate_sel} == $past({reg_wdata[6:5], reg_wdata[3:0]}))
    else $error("rate fields not taken");
  a_lpf_write: assert property (wr_ok && reg_addr == 8'h21
    && reg_wdata[2:0] inside {[3'h1:3'h6]} |=> lpf_rate_sel == $past(reg_wdata[2:0]))
    else $error("lpf code not taken");
  a_lpf_valid: assert property (lpf_rate_valid == (lpf_rate_sel inside {[3'h1:3'h6]}))
    else $error("lpf valid flag wrong");
  a_reboot_set: assert property (wr_ok && reg_addr == 8'h1d && reg_wdata[7]
    |=> reboot_busy)
    else $error("reboot not started");
  a_reboot_end: assert property ($rose(reboot_busy) |-> ##[1:RB_MAX] !reboot_busy)
    else $error("reboot never finished");
  a_feat_read: assert property (reg_rd && reg_addr == 8'h1d |=>
    {reg_rdata[7:5], reg_rdata[3:0]}
      == $past({reboot_busy, tilt_rate_sel, tap_rate_sel, motion_rate_sel}))
    else $error("feature readback wrong");
  a_release_clr: assert property (reg_rd && reg_addr == 8'h1a && !orient_enter
    && !tap_event && !motion_axis |=> !irq_pending)
    else $error("release did not clear");
  a_pend_cause: assert property ($rose(irq_pending)
    |-> $past(|{orient_enter, tap_event, motion_axis}))
    else $error("pending without event");
endmodule : msc_checker

bind msc_config_regs msc_checker #(.REBOOT_LEN(REBOOT_LEN)) u_chk
(
  .clock, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
  .operating_mode_bit, .orient_enter, .tap_event, .motion_axis, .reboot_busy,
  .tilt_rate_sel, .tap_rate_sel, .motion_rate_sel, .lpf_rate_sel,
  .lpf_rate_valid, .irq_pending
);

// ==== testbench/msc_host.sv ====
// Host side of the register port, byte strobes.
// Assumes the bench calls wr and rd after reset release.
`timescale 1ns/1ps
module msc_host
(
  input  wire logic       clock,
  output      logic [7:0] reg_addr,
  output      logic       reg_wr,
  output      logic [7:0] reg_wdata,
  output      logic       reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // Idle port at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // Data stands one cycle only, so taken at the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clock);
    d = reg_rdata;
  endtask : rd
endmodule : msc_host

// ==== testbench/motion_sensor_config_regs_test.sv ====
// Self-checking bench for the config register group.
// Assumes msc_host drives the register port.
`timescale 1ns/1ps
module motion_sensor_config_regs_test;
  localparam int PL = 8;
  localparam int RL = 16;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic op = 1'b0;
  logic [2:0] en = 3'h7;
  logic [5:0] oe = 6'h00;
  logic [5:0] te = 6'h00;
  logic [2:0] ma = 3'h0;
  logic ms = 1'b0;
  logic signed [msc_pkg::ACC_W-1:0] din = '0;
  logic [7:0] a, wd, rdat, d;
  logic wr, rd, busy, lv, pend, pin;
  logic [1:0] tilt, tap, mot;
  logic [2:0] lpf;
  logic signed [msc_pkg::ACC_W-1:0] hpf;
  logic [7:0] ads [6] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21};
  logic [7:0] rsv [6] = '{8'h3f, 8'h4d, 8'h10, 8'he0, 8'h3f, 8'h02};
  logic [7:0] wms [6] = '{8'h3f, 8'h6f, 8'h3c, 8'he0, 8'h3f, 8'hc7};
  int mdl [6];
  int n_mismatch = 0;
  int n_checks = 0;
  int n;
  int hy = 0;
  int hx = 0;
  int hv;
  int hk;
  logic hgo = 1'b0;
  logic rdone = 1'b0;

  always #2 clock = ~clock;
  // Random samples keep the filter path busy
  always @(posedge clock)
  begin
    ms <= ($urandom & 7) == 0;
    din <= 16'($urandom);
  end

  // filter model; inputs read at the negedge before the edge that takes them
  always @(negedge clock)
  begin
    if (hgo)
      cmp_hpf(hpf, hy);
    hgo = 1'b1;
    if (reset)
    begin
      hy = 0;
      hx = 0;
    end
    else if (ms)
    begin
      // beta is 1 - 2^-(3 + roll-off code)
      hk = 3 + ((mdl[5] >> 6) & 3);
      hv = hy + din - hx;
      hy = shortint'(hv - (hv >>> hk));
      hx = din;
    end
  end

  msc_host u_host (.clock(clock), .reg_addr(a), .reg_wr(wr), .reg_wdata(wd),
    .reg_rd(rd), .reg_rdata(rdat));
  msc_config_regs #(.PULSE_LEN(PL), .REBOOT_LEN(RL)) dut (.clock(clock), .reset(reset),
    .reg_addr(a), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdat),
    .operating_mode_bit(op), .motion_enable(en[0]), .tap_enable(en[1]),
    .tilt_enable(en[2]), .orient_enter(oe), .tap_event(te), .motion_axis(ma),
    .motion_sample_en(ms), .motion_din(din), .reboot_done(rdone), .reboot_busy(busy),
    .tilt_rate_sel(tilt), .tap_rate_sel(tap), .motion_rate_sel(mot),
    .lpf_rate_sel(lpf), .lpf_rate_valid(lv), .hpf_out(hpf), .irq_pending(pend),
    .irq_pin(pin));

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : cmp

  task automatic cmp_hpf(input logic signed [15:0] g, input int e);
    n_checks++;
    if (g !== 16'(e))
    begin
      n_mismatch++;
      $display("BAD %0t filter got %0d want %0d", $time, g, e);
    end
  endtask : cmp_hpf

  task automatic chk(input logic [7:0] ad, input logic [7:0] e);
    logic [7:0] g;
    u_host.rd(ad, g);
    cmp(g, e);
  endtask : chk

  // Model keeps only writes made in stand-by
  task automatic w(input int i, input logic [7:0] v);
    u_host.wr(ads[i], v);
    if (!op)
      mdl[i] = v & wms[i];
  endtask : w

  task automatic fire(input logic [5:0] o, input logic [5:0] t, input logic [2:0] m);
    @(posedge clock);
    oe <= o;
    te <= t;
    ma <= m;
    @(posedge clock);
    oe <= 6'h00;
    te <= 6'h00;
    ma <= 3'h0;
    @(negedge clock);
  endtask : fire

  // Main sequence
  initial
  begin
    void'($urandom(58603));
    for (int i = 0; i < 6; i++) mdl[i] = rsv[i];
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) chk(ads[i], mdl[i]);
    chk(8'h0c, 8'h55);
    chk(8'h30, 8'h00);
    cmp(pin, 1'b0);
    // Random stand-by writes; reboot bit and lpf codes 0 and 7 avoided
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($urandom);
      if (i == 1) d &= 8'h6f;
      if (i == 5) d = (d & 8'hfb) | 8'h01;
      w(i, d);
      chk(ads[i], mdl[i]);
    end
    @(posedge clock);
    op <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      w(i, 8'(~mdl[i]) & 8'h6f);
      chk(ads[i], mdl[i]);
    end
    @(posedge clock);
    op <= 1'b0;
    u_host.wr(8'h1d, 8'(mdl[1]) | 8'h10);
    chk(8'h0c, 8'haa);
    chk(8'h0c, 8'h55);
    chk(8'h1d, mdl[1]);
    // Latched, active high, one state masked
    w(0, 8'h3e);
    w(2, 8'h30);
    w(3, 8'he0);
    w(4, 8'h3f);
    fire(6'h01, 6'h00, 3'h0);
    cmp(pend, 1'b0);
    fire(6'h02, 6'h00, 3'h0);
    cmp(pin, 1'b1);
    repeat (3) @(negedge clock);
    cmp(pin, 1'b1);
    u_host.rd(8'h1a, d);
    cmp({pin, pend}, 2'b00);
    // Pulse length
    w(2, 8'h38);
    fire(6'h02, 6'h00, 3'h0);
    n = 0;
    while (pin === 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    cmp(8'(n), 8'(PL));
    if (n >= 100) report_and_stop;
    u_host.rd(8'h1a, d);
    // Active low with one tap direction masked
    w(2, 8'h20);
    w(4, 8'h1f);
    fire(6'h00, 6'h20, 3'h0);
    cmp(pend, 1'b0);
    fire(6'h00, 6'h10, 3'h0);
    cmp(pin, 1'b0);
    u_host.rd(8'h1a, d);
    cmp(pin, 1'b1);
    // Pin disabled, X axis only
    w(2, 8'h00);
    w(3, 8'h80);
    fire(6'h00, 6'h00, 3'h1);
    cmp(pend, 1'b0);
    fire(6'h00, 6'h00, 3'h4);
    cmp({pend, pin}, 2'b11);
    u_host.rd(8'h1a, d);
    // Unlatched, motion alone
    @(posedge clock);
    en <= 3'h1;
    w(2, 8'h34);
    w(3, 8'he0);
    @(posedge clock);
    ma <= 3'h4;
    repeat (2) @(negedge clock);
    cmp(pin, 1'b1);
    @(posedge clock);
    ma <= 3'h0;
    repeat (2) @(negedge clock);
    cmp(pin, 1'b0);
    u_host.rd(8'h1a, d);
    // Reboot holds busy then drops
    u_host.wr(8'h1d, 8'(mdl[1]) | 8'h80);
    @(negedge clock);
    cmp(busy, 1'b1);
    n = 0;
    while (busy === 1'b1 && n < RL + 4)
    begin
      @(negedge clock);
      n++;
    end
    cmp(busy, 1'b0);
    // Reboot ended early by the done strobe
    u_host.wr(8'h1d, 8'(mdl[1]) | 8'h80);
    repeat (2) @(posedge clock);
    rdone <= 1'b1;
    @(posedge clock);
    rdone <= 1'b0;
    @(negedge clock);
    cmp(busy, 1'b0);
    report_and_stop;
  end
endmodule : motion_sensor_config_regs_test
